/* File: src/pfs_fault_supervisor.sv */
// PFC fault supervisor: fault set/clear matrix and drive gating
//
// The implementer's own choices: the plain strobed port and the address map.
`default_nettype none
// What this block does
// - A line held below the brownout stop level past the sag blanking starts soft stop, and drives stop only once it completes.
// - During a sag, power-good drops only with static overvoltage or bulk undervoltage, and the bulk restart timer is cancelled.
// - A brownout resets the controller, disables polarity, drops power-good only under static overvoltage, and clears above the start level.
// - An out-of-window line period stops the rectifier drives and starts a delay whose expiry stops PWM and drops power-good, clearing after 4 good toggles.
// - Feedback above the soft overvoltage level runs the soft overvoltage sequence, then stops PWM, clearing below the recovery level.
// - Feedback above the hard overvoltage level stops PWM at once, clearing below the recovery level.
// - In both overvoltage faults polarity and rectifier drives keep running.
// - Every fault has its own set, clear and actions; only sag with bulk undervoltage and the two line-frequency stages look at each other's flags.
// - Skip and bulk undervoltage stay barred until the internal power-good flag has been set.
// - Power-good stays low at startup until feedback reaches 98% of the reference.
// - Fault-pin overtemperature is ignored for 5 ms after power-up.
// - A fault-pin fault is declared only after persisting past its 30 us blanking delay.
module pfs_fault_supervisor #(
   parameter int OTP_BLANK_CYC = pfs_pkg::OTP_BLANK_CYC,
   parameter int FLT_DLY_CYC   = pfs_pkg::FLT_DLY_CYC,
   parameter int SAG_BLANK_CYC = pfs_pkg::SAG_BLANK_CYC,
   parameter int BO_BLANK_CYC  = pfs_pkg::BO_BLANK_CYC,
   parameter int LF_DLY_CYC    = pfs_pkg::LF_DLY_CYC,
   parameter int BUV_RST_CYC   = pfs_pkg::BUV_RST_CYC
) (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   arst_n_i,
   // Register port
   input  wire logic [pfs_pkg::AW-1:0] reg_addr_i,
   input  wire logic [pfs_pkg::DW-1:0] reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output logic      [pfs_pkg::DW-1:0] reg_rdata_o,
   output logic                        irq_o,
   // Line comparators
   input  wire logic                   line_below_stop_i,
   input  wire logic                   line_above_start_i,
   input  wire logic                   line_period_valid_i,
   input  wire logic                   line_period_in_range_i,
   // Feedback comparators
   input  wire logic                   fb_at_regulation_i,
   input  wire logic                   fb_below_uvp_i,
   input  wire logic                   fb_above_uvp_hys_i,
   input  wire logic                   fb_below_buv_i,
   input  wire logic                   fb_above_soft_ovp_i,
   input  wire logic                   fb_above_hard_ovp_i,
   input  wire logic                   fb_below_ovp_recover_i,
   input  wire logic                   static_overvoltage_i,
   // Supply, fault pin and temperature
   input  wire logic                   vcc_below_off_i,
   input  wire logic                   vcc_above_on_i,
   input  wire logic                   flt_below_otp_i,
   input  wire logic                   flt_above_rec_i,
   input  wire logic                   flt_above_ovp_i,
   input  wire logic                   tj_above_shdn_i,
   input  wire logic                   tj_below_hys_i,
   input  wire logic                   master_reset_i,
   // Sequence handshakes
   input  wire logic                   soft_stop_done_i,
   input  wire logic                   soft_ovp_done_i,
   // Drive gating
   output logic                        pwm_enable_o,
   output logic                        sync_rectifier_drive_en_o,
   output logic                        polarity_en_o,
   output logic                        power_good_output_o,
   output logic                        soft_stop_req_o,
   output logic                        soft_ovp_req_o,
   output logic                        controller_reset_o,
   output logic                        skip_allow_o
);
   typedef struct packed {
      logic [pfs_pkg::NFLT-1:0]  flt;
      logic [pfs_pkg::NFLT-1:0]  flt_prev;
      logic                      stop_done;
      logic                      sovp_done;
      logic                      pg_flag;
      logic [pfs_pkg::TOG_W-1:0] good_tog;
      logic [pfs_pkg::NOUT-1:0]  outs;
   } pfs_sup_t;

   localparam logic [pfs_pkg::TOG_W-1:0] TOG_DONE = pfs_pkg::TOG_W'(pfs_pkg::LF_GOOD_TOG);

   pfs_sup_t s_q;
   pfs_sup_t s_d;

   logic sag_hit;
   logic bo_hit;
   logic blank_done;
   logic otp_hit;
   logic fovp_hit;
   logic lf_dly_done;
   logic buv_done;
   logic buv_run;
   logic lf_run;

   if (OTP_BLANK_CYC < 1 || FLT_DLY_CYC < 1 || SAG_BLANK_CYC < 1 ||
       BO_BLANK_CYC < 1 || LF_DLY_CYC < 1 || BUV_RST_CYC < 1) begin : g_chk
      $error("pfs_fault_supervisor: every count must be at least 1");
   end

   // Timers stop, and so restart from zero, whenever their fault drops
   assign buv_run = s_q.flt[pfs_pkg::F_BUV] & ~s_q.flt[pfs_pkg::F_SAG];
   assign lf_run  = s_q.flt[pfs_pkg::F_LF1] & ~s_q.flt[pfs_pkg::F_LF2];

   pfs_persist #(.CYCLES(SAG_BLANK_CYC)) u_sag_blank (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (line_below_stop_i),
      .hit_o     (sag_hit)
   );

   pfs_persist #(.CYCLES(BO_BLANK_CYC)) u_bo_blank (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (line_below_stop_i),
      .hit_o     (bo_hit)
   );

   // Power-up blanking: the condition is the constant one, so it runs once
   pfs_persist #(.CYCLES(OTP_BLANK_CYC)) u_otp_blank (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (1'b1),
      .hit_o     (blank_done)
   );

   pfs_persist #(.CYCLES(FLT_DLY_CYC)) u_otp_dly (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (flt_below_otp_i & blank_done),
      .hit_o     (otp_hit)
   );

   pfs_persist #(.CYCLES(FLT_DLY_CYC)) u_fovp_dly (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (flt_above_ovp_i),
      .hit_o     (fovp_hit)
   );

   pfs_persist #(.CYCLES(LF_DLY_CYC)) u_lf_dly (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (lf_run),
      .hit_o     (lf_dly_done)
   );

   pfs_persist #(.CYCLES(BUV_RST_CYC)) u_buv_tmr (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .cond_i    (buv_run),
      .hit_o     (buv_done)
   );

   pfs_regs u_regs (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .addr_i    (reg_addr_i),
      .wdata_i   (reg_wdata_i),
      .wr_i      (reg_wr_i),
      .rd_i      (reg_rd_i),
      .rdata_o   (reg_rdata_o),
      .fault_i   (s_q.flt),
      .event_i   (s_q.flt & ~s_q.flt_prev),
      .outs_i    (s_q.outs),
      .irq_o     (irq_o)
   );

   // Each fault: set wins over its own clear; only sag with bulk undervoltage and the two line-frequency stages look at each other's flags
   always_comb begin
      logic [pfs_pkg::NFLT-1:0] f;
      logic [pfs_pkg::NFLT-1:0] set;
      logic [pfs_pkg::NFLT-1:0] clr;
      logic                     good;
      logic                     pwm_off;
      logic                     sr_off;
      logic                     pol_off;
      logic                     pg_low;
      f   = s_q.flt;
      set = '0;
      clr = '0;
      s_d = s_q;
      good = line_period_valid_i & line_period_in_range_i;
      pwm_off = 1'b0;
      sr_off  = 1'b0;
      pol_off = 1'b0;
      pg_low  = 1'b0;

      set[pfs_pkg::F_SAG]  = sag_hit;
      clr[pfs_pkg::F_SAG]  = line_above_start_i;
      set[pfs_pkg::F_BO]   = bo_hit;
      clr[pfs_pkg::F_BO]   = line_above_start_i;
      set[pfs_pkg::F_LF1]  = line_period_valid_i & ~line_period_in_range_i;
      clr[pfs_pkg::F_LF1]  = good;
      set[pfs_pkg::F_LF2]  = lf_dly_done;
      clr[pfs_pkg::F_LF2]  = good && s_q.good_tog == TOG_DONE - 1'b1;
      set[pfs_pkg::F_UVP]  = fb_below_uvp_i;
      clr[pfs_pkg::F_UVP]  = fb_above_uvp_hys_i;
      // Re-arms one cycle after expiry, so a lasting bulk undervoltage retries each period
      set[pfs_pkg::F_BUV]  = s_q.pg_flag & fb_below_buv_i & ~f[pfs_pkg::F_BUV];
      clr[pfs_pkg::F_BUV]  = buv_done;
      set[pfs_pkg::F_SOVP] = fb_above_soft_ovp_i;
      clr[pfs_pkg::F_SOVP] = fb_below_ovp_recover_i;
      set[pfs_pkg::F_HOVP] = fb_above_hard_ovp_i;
      clr[pfs_pkg::F_HOVP] = fb_below_ovp_recover_i;
      set[pfs_pkg::F_UVLO] = vcc_below_off_i;
      clr[pfs_pkg::F_UVLO] = vcc_above_on_i;
      set[pfs_pkg::F_OTP]  = otp_hit;
      clr[pfs_pkg::F_OTP]  = flt_above_rec_i;
      set[pfs_pkg::F_FOVP] = fovp_hit;
      clr[pfs_pkg::F_FOVP] = master_reset_i;
      set[pfs_pkg::F_TSD]  = tj_above_shdn_i;
      clr[pfs_pkg::F_TSD]  = tj_below_hys_i;

      s_d.flt      = set | (f & ~clr);
      s_d.flt_prev = f;

      // Good-toggle run resets on any out-of-window period
      if (line_period_valid_i) begin
         if (!line_period_in_range_i) begin
            s_d.good_tog = '0;
         end else if (s_q.good_tog != TOG_DONE) begin
            s_d.good_tog = s_q.good_tog + 1'b1;
         end
      end

      // Sequence completion is held for the life of its fault
      s_d.stop_done = s_d.flt[pfs_pkg::F_SAG] & (s_q.stop_done | soft_stop_done_i);
      s_d.sovp_done = s_d.flt[pfs_pkg::F_SOVP] & (s_q.sovp_done | soft_ovp_done_i);
      s_d.pg_flag   = s_q.pg_flag | fb_at_regulation_i;

      // Soft and hard overvoltage faults touch only the PWM term
      pwm_off = s_d.stop_done | s_d.sovp_done | s_d.flt[pfs_pkg::F_HOVP] |
                s_d.flt[pfs_pkg::F_BO] | s_d.flt[pfs_pkg::F_LF2] |
                s_d.flt[pfs_pkg::F_UVP] | s_d.flt[pfs_pkg::F_BUV] |
                s_d.flt[pfs_pkg::F_UVLO] | s_d.flt[pfs_pkg::F_OTP] |
                s_d.flt[pfs_pkg::F_FOVP] | s_d.flt[pfs_pkg::F_TSD];
      sr_off  = s_d.stop_done | s_d.flt[pfs_pkg::F_BO] |
                s_d.flt[pfs_pkg::F_LF1] | s_d.flt[pfs_pkg::F_LF2] |
                s_d.flt[pfs_pkg::F_UVP] | s_d.flt[pfs_pkg::F_BUV] |
                s_d.flt[pfs_pkg::F_UVLO] | s_d.flt[pfs_pkg::F_OTP] |
                s_d.flt[pfs_pkg::F_FOVP] | s_d.flt[pfs_pkg::F_TSD];
      pol_off = s_d.flt[pfs_pkg::F_BO] | s_d.flt[pfs_pkg::F_UVLO];
      pg_low  = ~s_d.pg_flag |
                (s_d.flt[pfs_pkg::F_SAG] &
                 (static_overvoltage_i | s_d.flt[pfs_pkg::F_BUV])) |
                (s_d.flt[pfs_pkg::F_BO] & static_overvoltage_i) |
                s_d.flt[pfs_pkg::F_LF2] | s_d.flt[pfs_pkg::F_UVP] |
                s_d.flt[pfs_pkg::F_BUV] | s_d.flt[pfs_pkg::F_UVLO] |
                s_d.flt[pfs_pkg::F_OTP] | s_d.flt[pfs_pkg::F_FOVP] |
                s_d.flt[pfs_pkg::F_TSD];

      s_d.outs[pfs_pkg::O_PWM]  = ~pwm_off;
      s_d.outs[pfs_pkg::O_SR]   = ~sr_off;
      s_d.outs[pfs_pkg::O_POL]  = ~pol_off;
      s_d.outs[pfs_pkg::O_PG]   = ~pg_low;
      s_d.outs[pfs_pkg::O_STOP] = s_d.flt[pfs_pkg::F_SAG] & ~s_d.stop_done;
      s_d.outs[pfs_pkg::O_SOVP] = s_d.flt[pfs_pkg::F_SOVP] & ~s_d.sovp_done;
      s_d.outs[pfs_pkg::O_CRST] = s_d.flt[pfs_pkg::F_BO];
      s_d.outs[pfs_pkg::O_SKIP] = s_d.pg_flag;
   end

   // Everything starts disabled; drives come up one edge after release
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pwm_enable_o              = s_q.outs[pfs_pkg::O_PWM];
   assign sync_rectifier_drive_en_o = s_q.outs[pfs_pkg::O_SR];
   assign polarity_en_o             = s_q.outs[pfs_pkg::O_POL];
   assign power_good_output_o       = s_q.outs[pfs_pkg::O_PG];
   assign soft_stop_req_o           = s_q.outs[pfs_pkg::O_STOP];
   assign soft_ovp_req_o            = s_q.outs[pfs_pkg::O_SOVP];
   assign controller_reset_o        = s_q.outs[pfs_pkg::O_CRST];
   assign skip_allow_o              = s_q.outs[pfs_pkg::O_SKIP];

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_stop_finish;
      s_q.flt[pfs_pkg::F_SAG] && soft_stop_done_i && !line_above_start_i;
   endsequence

   sequence s_sovp_finish;
      s_q.flt[pfs_pkg::F_SOVP] && soft_ovp_done_i && !fb_below_ovp_recover_i;
   endsequence

   stop_then_off_a: assert property (
      s_stop_finish |=> !pwm_enable_o && !sync_rectifier_drive_en_o && !soft_stop_req_o)
      else $error("drives still on after soft stop finished");

   sag_pg_low_a: assert property (
      s_q.flt[pfs_pkg::F_SAG] && $past(static_overvoltage_i) |-> !power_good_output_o)
      else $error("power-good high during sag with static overvoltage");

   sag_cancel_a: assert property (
      s_q.flt[pfs_pkg::F_SAG] && s_q.flt[pfs_pkg::F_BUV] |=> !buv_done)
      else $error("bulk restart timer ran during sag");

   bo_reset_a: assert property (
      s_q.flt[pfs_pkg::F_BO] |-> controller_reset_o && !polarity_en_o)
      else $error("brownout without controller reset or with polarity");

   lf_delay_a: assert property (
      $rose(s_q.flt[pfs_pkg::F_LF2]) |-> $past(lf_run, 1) && !pwm_enable_o
                                         && !power_good_output_o)
      else $error("line frequency stage two wrong");

   lf_clear_a: assert property (
      $fell(s_q.flt[pfs_pkg::F_LF2]) |-> $past(s_q.good_tog) == TOG_DONE - 1'b1)
      else $error("line frequency fault cleared without four good toggles");

   sovp_off_a: assert property (
      s_sovp_finish |=> !pwm_enable_o && !soft_ovp_req_o)
      else $error("PWM on after soft overvoltage sequence");

   hovp_now_a: assert property (
      fb_above_hard_ovp_i |=> !pwm_enable_o)
      else $error("PWM not stopped by hard overvoltage");

   ovp_keep_a: assert property (
      (s_q.flt[pfs_pkg::F_HOVP] || s_q.flt[pfs_pkg::F_SOVP]) && s_q.flt ==
      ((s_q.flt & ((1 << pfs_pkg::F_HOVP) | (1 << pfs_pkg::F_SOVP))))
      |-> polarity_en_o && sync_rectifier_drive_en_o)
      else $error("overvoltage stopped polarity or rectifier");

   fovp_latch_a: assert property (
      s_q.flt[pfs_pkg::F_FOVP] && !master_reset_i |=> s_q.flt[pfs_pkg::F_FOVP])
      else $error("fault-pin overvoltage released without master reset");

   buv_gate_a: assert property (
      !s_q.pg_flag |-> !skip_allow_o && !s_q.flt[pfs_pkg::F_BUV])
      else $error("skip or bulk undervoltage before regulation");

   pg_start_a: assert property (
      !s_q.pg_flag |-> !power_good_output_o)
      else $error("power-good high before regulation");

   otp_blank_a: assert property (
      !blank_done |-> !s_q.flt[pfs_pkg::F_OTP])
      else $error("overtemperature during power-up blanking");

   fovp_dly_a: assert property (
      $rose(fovp_hit) |-> $past(flt_above_ovp_i, 1) && $past(flt_above_ovp_i, 2))
      else $error("fault-pin overvoltage without persistence");
endmodule
`default_nettype wire

/* File: src/pfs_pkg.sv */
// Shared constants of the PFC fault supervisor
`default_nettype none
package pfs_pkg;
   // Timing
   localparam int CLK_MHZ       = 125;
   localparam int FLT_DLY_US    = 30;
   localparam int FLT_DLY_CYC   = FLT_DLY_US * CLK_MHZ;
   localparam int OTP_BLANK_MS  = 5;
   localparam int OTP_BLANK_CYC = OTP_BLANK_MS * 1000 * CLK_MHZ;
   localparam int SAG_BLANK_CYC = 2000;
   localparam int BO_BLANK_CYC  = 4000;
   localparam int LF_DLY_CYC    = 4000;
   localparam int BUV_RST_CYC   = 4000;
   localparam int LF_GOOD_TOG   = 4;
   localparam int TOG_W         = 3;
   // Fault vector positions
   localparam int NFLT   = 12;
   localparam int F_SAG  = 0;
   localparam int F_BO   = 1;
   localparam int F_LF1  = 2;
   localparam int F_LF2  = 3;
   localparam int F_UVP  = 4;
   localparam int F_BUV  = 5;
   localparam int F_SOVP = 6;
   localparam int F_HOVP = 7;
   localparam int F_UVLO = 8;
   localparam int F_OTP  = 9;
   localparam int F_FOVP = 10;
   localparam int F_TSD  = 11;
   // Output state positions
   localparam int NOUT   = 8;
   localparam int O_PWM  = 0;
   localparam int O_SR   = 1;
   localparam int O_POL  = 2;
   localparam int O_PG   = 3;
   localparam int O_STOP = 4;
   localparam int O_SOVP = 5;
   localparam int O_CRST = 6;
   localparam int O_SKIP = 7;
   // Register map
   localparam int AW = 4;
   localparam int DW = 32;
   localparam logic [AW-1:0]   A_FAULT    = 4'h0;
   localparam logic [AW-1:0]   A_IRQ_STAT = 4'h4;
   localparam logic [AW-1:0]   A_IRQ_MASK = 4'h8;
   localparam logic [AW-1:0]   A_OUTS     = 4'hc;
   localparam logic [NFLT-1:0] MASK_RST   = 12'h000;
endpackage
`default_nettype wire

/* File: src/pfs_persist.sv */
// Persistence qualifier: flags a condition held longer than a cycle count
`default_nettype none
module pfs_persist #(
   parameter int CYCLES = 16
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   // Condition and result
   input  wire logic cond_i,
   output logic      hit_o
);
   localparam int            CW      = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(CYCLES);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          hit;
   } pfs_pst_t;

   pfs_pst_t s_q;
   pfs_pst_t s_d;

   if (CYCLES < 1) begin : g_chk
      $error("pfs_persist: CYCLES must be at least 1");
   end

   // A single low cycle restarts the count
   always_comb begin
      s_d = s_q;
      if (!cond_i) begin
         s_d = '0;
      end else if (s_q.cnt == CNT_MAX) begin
         s_d.hit = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit_o = s_q.hit;
endmodule
`default_nettype wire

/* File: src/pfs_regs.sv */
// Register port, sticky fault events, mask and interrupt
`default_nettype none
module pfs_regs (
   // Clock and reset
   input  wire logic                     clk_sys_i,
   input  wire logic                     arst_n_i,
   // Register port
   input  wire logic [pfs_pkg::AW-1:0]   addr_i,
   input  wire logic [pfs_pkg::DW-1:0]   wdata_i,
   input  wire logic                     wr_i,
   input  wire logic                     rd_i,
   output logic      [pfs_pkg::DW-1:0]   rdata_o,
   // Block state
   input  wire logic [pfs_pkg::NFLT-1:0] fault_i,
   input  wire logic [pfs_pkg::NFLT-1:0] event_i,
   input  wire logic [pfs_pkg::NOUT-1:0] outs_i,
   output logic                          irq_o
);
   typedef struct packed {
      logic [pfs_pkg::NFLT-1:0] stat;
      logic [pfs_pkg::NFLT-1:0] mask;
      logic [pfs_pkg::DW-1:0]   rdata;
      logic                     irq;
   } pfs_reg_t;

   pfs_reg_t s_q;
   pfs_reg_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.rdata = '0;
      // New events win over a write-one clear in the same cycle
      if (wr_i && addr_i == pfs_pkg::A_IRQ_STAT) begin
         s_d.stat = s_q.stat & ~wdata_i[pfs_pkg::NFLT-1:0];
      end
      s_d.stat = s_d.stat | event_i;
      if (wr_i && addr_i == pfs_pkg::A_IRQ_MASK) begin
         s_d.mask = wdata_i[pfs_pkg::NFLT-1:0];
      end
      if (rd_i) begin
         unique case (addr_i)
            pfs_pkg::A_FAULT:    s_d.rdata[pfs_pkg::NFLT-1:0] = fault_i;
            pfs_pkg::A_IRQ_STAT: s_d.rdata[pfs_pkg::NFLT-1:0] = s_q.stat;
            pfs_pkg::A_IRQ_MASK: s_d.rdata[pfs_pkg::NFLT-1:0] = s_q.mask;
            pfs_pkg::A_OUTS:     s_d.rdata[pfs_pkg::NOUT-1:0] = outs_i;
            default:             s_d.rdata = '0;
         endcase
      end
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q      <= '0;
         s_q.mask <= pfs_pkg::MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign irq_o   = s_q.irq;
endmodule
`default_nettype wire

/* File: tb/pfs_seq_model.sv */
// Slow sequencer model that answers soft stop and soft overvoltage requests
`default_nettype none
module pfs_seq_model #(
   parameter int DLY = 20
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   // Requests and completions
   input  wire logic stop_req_i,
   input  wire logic ovp_req_i,
   output logic      stop_done_o,
   output logic      ovp_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int stop_cnt;
   int ovp_cnt;
   // Done only after a long ramp, so early gating of the drives shows up
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stop_cnt <= 0;
         ovp_cnt  <= 0;
      end else begin
         stop_cnt <= stop_req_i ? ((stop_cnt < DLY) ? stop_cnt + 1 : DLY) : 0;
         ovp_cnt  <= ovp_req_i ? ((ovp_cnt < DLY) ? ovp_cnt + 1 : DLY) : 0;
      end
   end
   assign stop_done_o = stop_req_i && (stop_cnt == DLY);
   assign ovp_done_o  = ovp_req_i && (ovp_cnt == DLY);
endmodule
`default_nettype wire

/* File: tb/pfs_fault_supervisor_bench.sv */
// Self-checking bench of the fault supervisor
`default_nettype none
module pfs_fault_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, irq_o, ss_done, so_done;
   logic [3:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic lbs, las, lpv, lpr, fb_reg, feedback_undervoltage, uvp_hys, bulk_undervoltage, sovp, hovp, ovp_rec, stat_ov;
   logic vcc_off, vcc_on, otp, flt_rec, fovp, thermal_shutdown, tsd_hys, mrst;
   logic pwm, sr, pol, pg, stop, sreq, crst, skip;
   wire logic [7:0] outs = {skip, crst, sreq, stop, pg, pol, sr, pwm};
   int err_total = 0;
   int checks = 0;
   // Shortened counts keep the run brief
   localparam int T_OTP = 20;
   localparam int T_FLT = 5;
   localparam int T_SAG = 8;
   localparam int T_BO  = 40;
   localparam int T_TMR = 8;
   pfs_fault_supervisor #(.OTP_BLANK_CYC(T_OTP), .FLT_DLY_CYC(T_FLT), .SAG_BLANK_CYC(T_SAG),
      .BO_BLANK_CYC(T_BO), .LF_DLY_CYC(T_TMR), .BUV_RST_CYC(T_TMR)) dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .line_below_stop_i(lbs),
      .line_above_start_i(las), .line_period_valid_i(lpv), .line_period_in_range_i(lpr),
      .fb_at_regulation_i(fb_reg), .fb_below_uvp_i(feedback_undervoltage), .fb_above_uvp_hys_i(uvp_hys),
      .fb_below_buv_i(bulk_undervoltage), .fb_above_soft_ovp_i(sovp), .fb_above_hard_ovp_i(hovp),
      .fb_below_ovp_recover_i(ovp_rec), .static_overvoltage_i(stat_ov),
      .vcc_below_off_i(vcc_off), .vcc_above_on_i(vcc_on), .flt_below_otp_i(otp),
      .flt_above_rec_i(flt_rec), .flt_above_ovp_i(fovp), .tj_above_shdn_i(thermal_shutdown),
      .tj_below_hys_i(tsd_hys), .master_reset_i(mrst), .soft_stop_done_i(ss_done),
      .soft_ovp_done_i(so_done), .pwm_enable_o(pwm), .sync_rectifier_drive_en_o(sr),
      .polarity_en_o(pol), .power_good_output_o(pg), .soft_stop_req_o(stop),
      .soft_ovp_req_o(sreq), .controller_reset_o(crst), .skip_allow_o(skip));
   pfs_seq_model seq (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .stop_req_i(stop), .ovp_req_i(sreq), .stop_done_o(ss_done), .ovp_done_o(so_done));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic at(input int n, input logic [7:0] exp);
      repeat (n) @(posedge clk_sys_i);
      #1 chk({24'h0, outs}, {24'h0, exp}, "outputs");
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'h1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'h1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'h0;
      #1 chk(reg_rdata_o, exp, "read data");
   endtask
   // One measured line period, good or out of window
   task automatic per(input logic ok);
      @(posedge clk_sys_i);
      lpv <= 1'h1;
      lpr <= ok;
      @(posedge clk_sys_i);
      lpv <= 1'h0;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'h0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      err_total++;
      results();
   end
   initial begin
      arst_n_i = 1'h0;
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, lbs, las, lpv, lpr, fb_reg, feedback_undervoltage} <= '0;
      {uvp_hys, sovp, hovp, ovp_rec, stat_ov, vcc_off, vcc_on, flt_rec, fovp} <= '0;
      {thermal_shutdown, tsd_hys, mrst} <= '0;
      otp <= 1'h1;
      bulk_undervoltage <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'h1;
      at(10, 8'h07);
      at(30, 8'h04);
      rd(pfs_pkg::A_FAULT, 32'h200);
      otp <= 1'h0;
      flt_rec <= 1'h1;
      bulk_undervoltage <= 1'h0;
      fb_reg <= 1'h1;
      at(3, 8'h8f);
      wr(pfs_pkg::A_IRQ_STAT, 32'hfff);
      wr(pfs_pkg::A_IRQ_MASK, 32'h80);
      rd(pfs_pkg::A_IRQ_MASK, 32'h80);
      rd(4'h1, 32'h0);
      hovp <= 1'h1;
      at(3, 8'h8e);
      chk({31'h0, irq_o}, 32'h1, "irq");
      rd(pfs_pkg::A_IRQ_STAT, 32'h80);
      rd(pfs_pkg::A_OUTS, 32'h8e);
      hovp <= 1'h0;
      ovp_rec <= 1'h1;
      at(3, 8'h8f);
      ovp_rec <= 1'h0;
      wr(pfs_pkg::A_IRQ_STAT, 32'h80);
      at(2, 8'h8f);
      chk({31'h0, irq_o}, 32'h0, "irq");
      sovp <= 1'h1;
      at(8, 8'haf);
      at(25, 8'h8e);
      sovp <= 1'h0;
      ovp_rec <= 1'h1;
      at(3, 8'h8f);
      ovp_rec <= 1'h0;
      lbs <= 1'h1;
      at(20, 8'h9f);
      at(16, 8'h8c);
      at(24, 8'hc8);
      stat_ov <= 1'h1;
      at(3, 8'hc0);
      lbs <= 1'h0;
      las <= 1'h1;
      stat_ov <= 1'h0;
      at(3, 8'h8f);
      feedback_undervoltage <= 1'h1;
      thermal_shutdown <= 1'h1;
      at(3, 8'h84);
      feedback_undervoltage <= 1'h0;
      uvp_hys <= 1'h1;
      at(3, 8'h84);
      thermal_shutdown <= 1'h0;
      tsd_hys <= 1'h1;
      at(3, 8'h8f);
      fovp <= 1'h1;
      at(12, 8'h84);
      fovp <= 1'h0;
      at(10, 8'h84);
      mrst <= 1'h1;
      at(3, 8'h8f);
      mrst <= 1'h0;
      vcc_off <= 1'h1;
      at(3, 8'h80);
      vcc_off <= 1'h0;
      vcc_on <= 1'h1;
      at(3, 8'h8f);
      bulk_undervoltage <= 1'h1;
      at(3, 8'h84);
      bulk_undervoltage <= 1'h0;
      at(15, 8'h8f);
      per(1'h0);
      at(2, 8'h8d);
      at(12, 8'h84);
      repeat (3) per(1'h1);
      at(2, 8'h84);
      per(1'h1);
      at(2, 8'h8f);
      // Bulk undervoltage inside a sag: no restart retry may fire
      lbs <= 1'h1;
      las <= 1'h0;
      at(11, 8'h9f);
      bulk_undervoltage <= 1'h1;
      at(3, 8'h94);
      wr(pfs_pkg::A_IRQ_STAT, 32'hfff);
      at(12, 8'h94);
      rd(pfs_pkg::A_IRQ_STAT, 32'h0);
      lbs <= 1'h0;
      las <= 1'h1;
      bulk_undervoltage <= 1'h0;
      at(2, 8'h84);
      at(10, 8'h8f);
      results();
   end
endmodule
`default_nettype wire
